// *** logic/dbcs_pkg.sv ***
// Constants, carriers and state types of the dual boot config sequencer
package dbcs_pkg;
	localparam int CLK_MHZ = 50;
	localparam int INIT_LOW_NS = 2000;
	localparam int INIT_PULSE_NS = 1000;
	localparam logic [15:0] INIT_LOW_CYC =
		16'((INIT_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [15:0] INIT_PULSE_CYC =
		16'((INIT_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam int OSC_KHZ = 8000;
	localparam int DEFAULT_KHZ = 3100;
	localparam int MIN_HALF_I = 3;
	localparam int DEF_HALF_I =
		(OSC_KHZ + 2 * DEFAULT_KHZ - 1) / (2 * DEFAULT_KHZ);
	localparam logic [7:0] MIN_HALF = 8'(MIN_HALF_I);
	localparam logic [7:0] DEF_HALF =
		8'((DEF_HALF_I > MIN_HALF_I) ? DEF_HALF_I : MIN_HALF_I);
	localparam logic [7:0] READ_CMD = 8'h03;
	localparam logic [23:0] START_ADDR = 24'h000000;
	localparam logic [31:0] CMD_WORD = {READ_CMD, START_ADDR};
	localparam logic [15:0] CMD_BITS = 16'h0020;
	localparam logic [15:0] HDR_BITS = 16'h0080;
	localparam logic [15:0] RATE_BITS = 16'h0008;
	localparam logic [15:0] WORD_BITS = 16'h0010;
	localparam logic [15:0] PREAMBLE = 16'hBDB3;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam logic [15:0] CRC16_INIT = 16'hFFFF;
	localparam logic [31:0] CRC32_POLY = 32'h04C11DB7;
	localparam logic [31:0] CRC32_INIT = 32'hFFFFFFFF;
	localparam logic [15:0] SEC_WORDS = 16'h0010;
	localparam logic [2:0] FUSE_ROWS = 3'h4;

	typedef struct packed {
		logic lo;
		logic hi;
	} dbcs_boot_sel_t;

	typedef struct packed {
		logic timeout;
		logic crc_err;
	} dbcs_spi_res_t;

	typedef struct packed {
		logic req;
		logic erase;
	} dbcs_fuse_req_t;

	typedef enum {S_INIT, S_WAIT_HI, S_DECIDE, S_FUSE, S_SDM, S_SPI,
		S_PULSE, S_WAKE, S_FAIL, S_STOP} dbcs_sys_st_t;

	typedef enum {L_IDLE, L_CMD, L_HDR, L_HUNT, L_RATE, L_LEN, L_DATA,
		L_CRC, L_END, L_REPORT} dbcs_lnk_st_t;
endpackage

// *** logic/dbcs_top.sv ***
// Dual boot configuration sequencer with serial flash read engine
`timescale 1ns/1ns
module dbcs_top #(
	parameter int SPI_TIMEOUT_CLOCKS = 16384
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic config_osc_clock,
	input wire dbcs_pkg::dbcs_boot_sel_t boot_select,
	input wire logic reprogram_request_n,
	input wire logic jtag_refresh,
	input wire logic init_status_n_in,
	output logic init_status_n_out,
	output logic init_status_n_oe,
	output logic done_pin_out,
	output logic done_pin_oe,
	input wire logic done_fuse_programmed,
	output logic sdm_start,
	input wire logic sdm_done,
	input wire logic sdm_error,
	output logic user_mode,
	output logic config_halted,
	output dbcs_pkg::dbcs_spi_res_t spi_status,
	output logic config_serial_clock,
	output logic flash_chip_select_n,
	output logic flash_mosi_pin,
	input wire logic flash_miso_pin,
	input wire dbcs_pkg::dbcs_fuse_req_t fuse_req,
	input wire logic fuse_ack,
	output logic [1:0] fuse_row,
	output logic fuse_is_done,
	output logic fuse_strobe,
	output logic fuse_busy,
	input wire logic sec_enable,
	output logic [15:0] readback_addr,
	input wire logic readback_valid,
	input wire logic [31:0] readback_data,
	input wire logic [31:0] readback_ref,
	output logic sec_busy,
	output logic sec_error
);
	import dbcs_pkg::*;

	function automatic logic [15:0] crc16_bit(input logic [15:0] c,
		input logic b);
		return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC16_POLY : 16'h0000);
	endfunction

	function automatic logic [31:0] crc32_word(input logic [31:0] c,
		input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC32_POLY : 32'h0);
		end
		return r;
	endfunction

	function automatic logic [2:0] fuse_map(input logic [2:0] step,
		input logic erase);
		logic [2:0] m;
		m = 3'h0;
		if (erase) begin
			m = {step == 3'h0, 2'(step - 3'h1)};
		end else begin
			m = {step == FUSE_ROWS, step[1:0]};
		end
		return m;
	endfunction

	dbcs_sys_st_t st_ff;
	dbcs_boot_sel_t sel_s1_ff, sel_s2_ff, sel_ff;
	dbcs_spi_res_t res_s1_ff, res_s2_ff, spi_res_ff;
	logic prog_s1_ff, prog_s2_ff, prog_prev_ff;
	logic init_s1_ff, init_s2_ff, init_prev_ff;
	logic dtg_s1_ff, dtg_s2_ff, dtg_seen_ff;
	logic [15:0] tmr_ff;
	logic second_ff, sdm_only_ff, emb_ff, start_tg_ff, sdm_start_ff;
	logic restart, spi_evt;
	logic done_tg_ff;
	dbcs_spi_res_t lres_ff;

	// Pin and crossing synchronisers on the system clock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sel_s1_ff <= '0;
			sel_s2_ff <= '0;
			prog_s1_ff <= 1'b1;
			prog_s2_ff <= 1'b1;
			prog_prev_ff <= 1'b1;
			init_s1_ff <= 1'b0;
			init_s2_ff <= 1'b0;
			init_prev_ff <= 1'b0;
			dtg_s1_ff <= 1'b0;
			dtg_s2_ff <= 1'b0;
			dtg_seen_ff <= 1'b0;
			res_s1_ff <= '0;
			res_s2_ff <= '0;
		end else begin
			sel_s1_ff <= boot_select;
			sel_s2_ff <= sel_s1_ff;
			prog_s1_ff <= reprogram_request_n;
			prog_s2_ff <= prog_s1_ff;
			prog_prev_ff <= prog_s2_ff;
			init_s1_ff <= init_status_n_in;
			init_s2_ff <= init_s1_ff;
			init_prev_ff <= init_s2_ff;
			dtg_s1_ff <= done_tg_ff;
			dtg_s2_ff <= dtg_s1_ff;
			dtg_seen_ff <= dtg_s2_ff;
			res_s1_ff <= lres_ff;
			res_s2_ff <= res_s1_ff;
		end
	end

	assign restart = (prog_prev_ff & ~prog_s2_ff) | jtag_refresh;
	assign spi_evt = dtg_s2_ff ^ dtg_seen_ff;

	// Boot sequence controller
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff <= S_INIT;
			tmr_ff <= 16'h0000;
			sel_ff <= '0;
			second_ff <= 1'b0;
			sdm_only_ff <= 1'b0;
			emb_ff <= 1'b0;
			start_tg_ff <= 1'b0;
			sdm_start_ff <= 1'b0;
			spi_res_ff <= '0;
		end else begin
			sdm_start_ff <= 1'b0;
			if (restart) begin
				st_ff <= S_INIT;
				tmr_ff <= 16'h0000;
				second_ff <= 1'b0;
				sdm_only_ff <= 1'b0;
				emb_ff <= 1'b0;
				spi_res_ff <= '0;
			end else begin
				case (st_ff)
				S_INIT: begin
					if (tmr_ff == INIT_LOW_CYC - 16'h0001) begin
						st_ff <= S_WAIT_HI;
						tmr_ff <= 16'h0000;
					end else begin
						tmr_ff <= tmr_ff + 16'h0001;
					end
				end
				S_WAIT_HI: begin
					if (init_s2_ff & ~init_prev_ff) begin
						sel_ff <= sel_s2_ff;
						st_ff <= S_DECIDE;
					end
				end
				S_DECIDE: begin
					if (sel_ff.lo) begin
						sdm_only_ff <= 1'b1;
						sdm_start_ff <= done_fuse_programmed;
						st_ff <= done_fuse_programmed ? S_SDM : S_STOP;
					end else if (sel_ff.hi) begin
						st_ff <= S_FUSE;
					end else begin
						start_tg_ff <= ~start_tg_ff;
						st_ff <= S_SPI;
					end
				end
				S_FUSE: begin
					if (done_fuse_programmed) begin
						sdm_start_ff <= 1'b1;
						st_ff <= S_SDM;
					end else if (second_ff) begin
						st_ff <= S_STOP;
					end else begin
						second_ff <= 1'b1;
						start_tg_ff <= ~start_tg_ff;
						st_ff <= S_SPI;
					end
				end
				S_SDM: begin
					if (sdm_done) begin
						if (!sdm_error) begin
							emb_ff <= 1'b1;
							st_ff <= S_WAKE;
						end else if (sdm_only_ff | second_ff) begin
							st_ff <= S_FAIL;
						end else begin
							second_ff <= 1'b1;
							start_tg_ff <= ~start_tg_ff;
							st_ff <= S_SPI;
						end
					end
				end
				S_SPI: begin
					if (spi_evt) begin
						spi_res_ff <= res_s2_ff;
						if (res_s2_ff == '0) begin
							st_ff <= S_WAKE;
						end else if (second_ff) begin
							st_ff <= S_FAIL;
						end else begin
							second_ff <= 1'b1;
							tmr_ff <= 16'h0000;
							st_ff <= S_PULSE;
						end
					end
				end
				S_PULSE: begin
					if (tmr_ff == INIT_PULSE_CYC - 16'h0001) begin
						st_ff <= S_FUSE;
					end else begin
						tmr_ff <= tmr_ff + 16'h0001;
					end
				end
				default: begin
					st_ff <= st_ff;
				end
				endcase
			end
		end
	end

	assign init_status_n_out = 1'b0;
	assign init_status_n_oe = (st_ff == S_INIT) | (st_ff == S_PULSE) |
		(st_ff == S_FAIL);
	assign done_pin_out = 1'b0;
	assign done_pin_oe = (st_ff != S_WAKE);
	assign user_mode = (st_ff == S_WAKE);
	assign config_halted = (st_ff == S_FAIL) | (st_ff == S_STOP);
	assign sdm_start = sdm_start_ff;
	assign spi_status = spi_res_ff;

	// One-shot readback check after an embedded boot
	logic sec_busy_ff, sec_error_ff, sec_armed_ff;
	logic [15:0] rb_addr_ff;
	logic [31:0] sec_crc_ff;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sec_busy_ff <= 1'b0;
			sec_error_ff <= 1'b0;
			sec_armed_ff <= 1'b1;
			rb_addr_ff <= 16'h0000;
			sec_crc_ff <= CRC32_INIT;
		end else if (restart) begin
			sec_busy_ff <= 1'b0;
			sec_armed_ff <= 1'b1;
			sec_error_ff <= 1'b0;
		end else if (st_ff != S_WAKE) begin
			sec_busy_ff <= 1'b0;
			sec_armed_ff <= 1'b1;
		end else if (sec_armed_ff) begin
			sec_armed_ff <= 1'b0;
			sec_busy_ff <= emb_ff & sec_enable;
			rb_addr_ff <= 16'h0000;
			sec_crc_ff <= CRC32_INIT;
		end else if (sec_busy_ff & readback_valid) begin
			sec_crc_ff <= crc32_word(sec_crc_ff, readback_data);
			rb_addr_ff <= rb_addr_ff + 16'h0001;
			if (rb_addr_ff == SEC_WORDS - 16'h0001) begin
				sec_busy_ff <= 1'b0;
				sec_error_ff <= crc32_word(sec_crc_ff, readback_data) !=
					readback_ref;
			end
		end
	end
	assign readback_addr = rb_addr_ff;
	assign sec_busy = sec_busy_ff;
	assign sec_error = sec_error_ff;

	// Embedded flash fuse ordering for erase and program
	logic fz_busy_ff, fz_erase_ff, fz_strobe_ff, fz_done_ff;
	logic [2:0] fz_step_ff;
	logic [1:0] fz_row_ff;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fz_busy_ff <= 1'b0;
			fz_erase_ff <= 1'b0;
			fz_strobe_ff <= 1'b0;
			fz_step_ff <= 3'h0;
			{fz_done_ff, fz_row_ff} <= 3'h0;
		end else begin
			fz_strobe_ff <= 1'b0;
			if (!fz_busy_ff & fuse_req.req) begin
				fz_busy_ff <= 1'b1;
				fz_erase_ff <= fuse_req.erase;
				fz_step_ff <= 3'h0;
				fz_strobe_ff <= 1'b1;
				{fz_done_ff, fz_row_ff} <=
					fuse_map(3'h0, fuse_req.erase);
			end else if (fz_busy_ff & fuse_ack) begin
				if (fz_step_ff == FUSE_ROWS) begin
					fz_busy_ff <= 1'b0;
				end else begin
					fz_step_ff <= fz_step_ff + 3'h1;
					fz_strobe_ff <= 1'b1;
					{fz_done_ff, fz_row_ff} <=
						fuse_map(fz_step_ff + 3'h1, fz_erase_ff);
				end
			end
		end
	end
	assign fuse_busy = fz_busy_ff;
	assign fuse_strobe = fz_strobe_ff;
	assign fuse_row = fz_row_ff;
	assign fuse_is_done = fz_done_ff;

	// Link domain: serial flash read engine on the configuration clock
	logic lrst_s1_ff, lrst_s2_ff;
	logic stg_s1_ff, stg_s2_ff, stg_seen_ff;
	logic miso_s1_ff, miso_s2_ff;
	logic l_start, tick;
	dbcs_lnk_st_t lst_ff;
	logic [7:0] half_ff, dcnt_ff;
	logic sck_ff, cs_n_ff, mosi_ff;
	logic [31:0] cmd_ff;
	logic [15:0] bcnt_ff, tmo_ff, sh_ff, len_ff, wcnt_ff, crc_ff, nsh;

	always_ff @(posedge config_osc_clock or posedge rst) begin
		if (rst) begin
			lrst_s1_ff <= 1'b1;
			lrst_s2_ff <= 1'b1;
		end else begin
			lrst_s1_ff <= 1'b0;
			lrst_s2_ff <= lrst_s1_ff;
		end
	end

	always_ff @(posedge config_osc_clock or posedge lrst_s2_ff) begin
		if (lrst_s2_ff) begin
			stg_s1_ff <= 1'b0;
			stg_s2_ff <= 1'b0;
			stg_seen_ff <= 1'b0;
			miso_s1_ff <= 1'b0;
			miso_s2_ff <= 1'b0;
		end else begin
			stg_s1_ff <= start_tg_ff;
			stg_s2_ff <= stg_s1_ff;
			stg_seen_ff <= stg_s2_ff;
			miso_s1_ff <= flash_miso_pin;
			miso_s2_ff <= miso_s1_ff;
		end
	end

	assign l_start = stg_s2_ff ^ stg_seen_ff;
	assign tick = (dcnt_ff == half_ff - 8'h01);
	assign nsh = {sh_ff[14:0], miso_s2_ff};

	always_ff @(posedge config_osc_clock or posedge lrst_s2_ff) begin
		if (lrst_s2_ff) begin
			lst_ff <= L_IDLE;
			lres_ff <= '0;
			half_ff <= DEF_HALF;
			dcnt_ff <= 8'h00;
			sck_ff <= 1'b0;
			cs_n_ff <= 1'b1;
			mosi_ff <= 1'b0;
			cmd_ff <= 32'h00000000;
			bcnt_ff <= 16'h0000;
			tmo_ff <= 16'h0000;
			sh_ff <= 16'h0000;
			len_ff <= 16'h0000;
			wcnt_ff <= 16'h0000;
			crc_ff <= CRC16_INIT;
			done_tg_ff <= 1'b0;
		end else if (l_start) begin
			lst_ff <= L_CMD;
			lres_ff <= '0;
			half_ff <= DEF_HALF;
			dcnt_ff <= 8'h00;
			sck_ff <= 1'b0;
			cs_n_ff <= 1'b0;
			mosi_ff <= CMD_WORD[31];
			cmd_ff <= {CMD_WORD[30:0], 1'b0};
			bcnt_ff <= 16'h0000;
		end else begin
			case (lst_ff)
			L_IDLE: begin
				cs_n_ff <= 1'b1;
			end
			L_END: begin
				cs_n_ff <= 1'b1;
				sck_ff <= 1'b0;
				mosi_ff <= 1'b0;
				lst_ff <= L_REPORT;
			end
			L_REPORT: begin
				done_tg_ff <= ~done_tg_ff;
				lst_ff <= L_IDLE;
			end
			default: begin
				if (tick) begin
					dcnt_ff <= 8'h00;
					sck_ff <= ~sck_ff;
				end else begin
					dcnt_ff <= dcnt_ff + 8'h01;
				end
				if (tick & sck_ff) begin
					mosi_ff <= cmd_ff[31];
					cmd_ff <= {cmd_ff[30:0], 1'b0};
				end
				if (tick & ~sck_ff) begin
					sh_ff <= nsh;
					bcnt_ff <= bcnt_ff + 16'h0001;
					case (lst_ff)
					L_CMD: begin
						if (bcnt_ff == CMD_BITS - 16'h0001) begin
							lst_ff <= L_HDR;
							bcnt_ff <= 16'h0000;
						end
					end
					L_HDR: begin
						if (bcnt_ff == HDR_BITS - 16'h0001) begin
							lst_ff <= L_HUNT;
							bcnt_ff <= 16'h0000;
							tmo_ff <= 16'h0000;
						end
					end
					L_HUNT: begin
						tmo_ff <= tmo_ff + 16'h0001;
						if (nsh == PREAMBLE) begin
							lst_ff <= L_RATE;
							bcnt_ff <= 16'h0000;
						end else if (tmo_ff ==
							16'(SPI_TIMEOUT_CLOCKS - 1)) begin
							lres_ff.timeout <= 1'b1;
							lst_ff <= L_END;
						end
					end
					L_RATE: begin
						if (bcnt_ff == RATE_BITS - 16'h0001) begin
							half_ff <= (nsh[7:0] < MIN_HALF) ? MIN_HALF :
								nsh[7:0];
							lst_ff <= L_LEN;
							bcnt_ff <= 16'h0000;
						end
					end
					L_LEN: begin
						if (bcnt_ff == WORD_BITS - 16'h0001) begin
							len_ff <= nsh;
							wcnt_ff <= 16'h0000;
							crc_ff <= CRC16_INIT;
							lst_ff <= (nsh == 16'h0000) ? L_CRC : L_DATA;
							bcnt_ff <= 16'h0000;
						end
					end
					L_DATA: begin
						crc_ff <= crc16_bit(crc_ff, miso_s2_ff);
						if (bcnt_ff == WORD_BITS - 16'h0001) begin
							bcnt_ff <= 16'h0000;
							wcnt_ff <= wcnt_ff + 16'h0001;
							if (wcnt_ff == len_ff - 16'h0001) begin
								lst_ff <= L_CRC;
							end
						end
					end
					L_CRC: begin
						if (bcnt_ff == WORD_BITS - 16'h0001) begin
							lres_ff.crc_err <= (nsh != crc_ff);
							lst_ff <= L_END;
						end
					end
					default: begin
						lst_ff <= lst_ff;
					end
					endcase
				end
			end
			endcase
		end
	end

	assign config_serial_clock = sck_ff;
	assign flash_chip_select_n = cs_n_ff;
	assign flash_mosi_pin = mosi_ff;
endmodule

// *** testbench/dbcs_checker.sv ***
// Assertion checker bound to the dual boot config sequencer top
`timescale 1ns/1ns
module dbcs_checker #(
	parameter int SPI_TIMEOUT_CLOCKS = 16384
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic config_osc_clock,
	input wire logic jtag_refresh,
	input wire logic init_status_n_oe,
	input wire logic done_pin_oe,
	input wire logic sdm_start,
	input wire logic user_mode,
	input wire logic config_halted,
	input wire logic config_serial_clock,
	input wire logic flash_chip_select_n,
	input wire logic flash_mosi_pin,
	input wire dbcs_pkg::dbcs_fuse_req_t fuse_req,
	input wire logic fuse_strobe,
	input wire logic fuse_is_done,
	input wire logic [1:0] fuse_row,
	input wire logic fuse_busy,
	input wire logic sec_busy
);
	import dbcs_pkg::*;
	a_refresh_init: assert property (@(posedge clock)
		disable iff (rst)
		jtag_refresh |=> (init_status_n_oe && !user_mode) [*8])
		else $error("init not held low after refresh");
	a_user_pins: assert property (@(posedge clock)
		disable iff (rst)
		user_mode |-> !done_pin_oe && !init_status_n_oe)
		else $error("pins wrong in user mode");
	a_done_user: assert property (@(posedge clock)
		disable iff (rst)
		!done_pin_oe |-> user_mode)
		else $error("done released outside user mode");
	a_halt_done: assert property (@(posedge clock)
		disable iff (rst)
		config_halted |-> !user_mode && done_pin_oe)
		else $error("halt with done released");
	a_sdm_pulse: assert property (@(posedge clock)
		disable iff (rst)
		sdm_start |-> flash_chip_select_n ##1 !sdm_start)
		else $error("self download start wrong");
	a_erase_first: assert property (@(posedge clock)
		disable iff (rst)
		fuse_req.req && fuse_req.erase && !fuse_busy |=>
		fuse_strobe && fuse_busy && fuse_is_done)
		else $error("erase does not start with done fuse");
	a_prog_first: assert property (@(posedge clock)
		disable iff (rst)
		fuse_req.req && !fuse_req.erase && !fuse_busy |=>
		fuse_strobe && !fuse_is_done && fuse_row == 2'h0)
		else $error("program does not start with row zero");
	a_sec_user: assert property (@(posedge clock)
		disable iff (rst)
		sec_busy |-> user_mode)
		else $error("readback check outside user mode");
	a_cs_sck: assert property (@(posedge config_osc_clock)
		disable iff (rst)
		$fell(flash_chip_select_n) |-> !config_serial_clock [*3])
		else $error("serial clock not idle at select");
	a_mosi_rise: assert property (@(posedge config_osc_clock)
		disable iff (rst)
		$rose(config_serial_clock) |-> $stable(flash_mosi_pin))
		else $error("mosi moved at clock rise");
endmodule

bind dbcs_top dbcs_checker #(.SPI_TIMEOUT_CLOCKS(SPI_TIMEOUT_CLOCKS)) u_chk (
	.clock(clock), .rst(rst), .config_osc_clock(config_osc_clock),
	.jtag_refresh(jtag_refresh), .init_status_n_oe(init_status_n_oe),
	.done_pin_oe(done_pin_oe), .sdm_start(sdm_start), .user_mode(user_mode),
	.config_halted(config_halted), .config_serial_clock(config_serial_clock),
	.flash_chip_select_n(flash_chip_select_n),
	.flash_mosi_pin(flash_mosi_pin), .fuse_req(fuse_req),
	.fuse_strobe(fuse_strobe), .fuse_is_done(fuse_is_done),
	.fuse_row(fuse_row), .fuse_busy(fuse_busy), .sec_busy(sec_busy)
);

// *** testbench/dbcs_flash_model.sv ***
// Behavioural serial flash holding the golden image
`timescale 1ns/1ns
module dbcs_flash_model (
	input wire logic flash_chip_select_n,
	input wire logic config_serial_clock,
	input wire logic flash_mosi_pin,
	input wire logic [1:0] image_mode,
	input wire logic [15:0] image_word,
	output logic flash_miso_pin,
	output logic [31:0] cmd_seen
);
	import dbcs_pkg::*;
	logic [199:0] image;
	int edges;
	function automatic logic [15:0] crc16(input logic [15:0] d);
		logic [15:0] c;
		c = CRC16_INIT;
		for (int i = 15; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC16_POLY : 16'h0000);
		return c;
	endfunction
	initial begin
		flash_miso_pin = 1'b0;
		cmd_seen = 32'h00000000;
	end
	// Image: header, preamble, slower rate, one word, its check value
	always @(negedge flash_chip_select_n) begin
		edges = 0;
		image = {{8{16'hA5C3}}, PREAMBLE, 8'h04,
			16'h0001, image_word,
			crc16(image_word) ^ {15'h0000, image_mode == 2'h2}};
		if (image_mode == 2'h1)
			image = '1;
	end
	always @(posedge config_serial_clock) begin
		if (!flash_chip_select_n) begin
			if (edges < 32)
				cmd_seen <= {cmd_seen[30:0], flash_mosi_pin};
			edges <= edges + 1;
		end
	end
	// Data moves on falling clock; outside data the line keeps changing
	always @(negedge config_serial_clock or posedge flash_chip_select_n) begin
		if (flash_chip_select_n || edges < 32 || edges >= 232)
			flash_miso_pin <= ~flash_miso_pin;
		else
			flash_miso_pin <= image[231 - edges];
	end
endmodule

// *** testbench/dbcs_top_bench.sv ***
// Self-checking bench for the dual boot config sequencer
`timescale 1ns/1ns
module dbcs_top_bench;
	import dbcs_pkg::*;
	localparam int LIMIT = 90000;
	logic clock = 0, rst = 1, config_osc_clock = 0, reprogram_request_n = 1;
	logic jtag_refresh = 0, done_fuse_programmed = 1, sdm_done = 0;
	logic sdm_error = 0, fuse_ack = 0, sec_enable = 0, readback_valid = 0;
	logic [31:0] readback_data = 0, readback_ref = 0, cmd_seen;
	dbcs_boot_sel_t boot_select = 2'h1;
	dbcs_fuse_req_t fuse_req = 2'h0;
	dbcs_spi_res_t spi_status;
	logic init_status_n_out, init_status_n_oe, done_pin_oe, sdm_start;
	logic user_mode, config_halted, config_serial_clock, flash_chip_select_n;
	logic flash_mosi_pin, flash_miso_pin, fuse_is_done, fuse_strobe;
	logic fuse_busy, sec_busy, sec_error, done_pin_out, prev_res = 0;
	logic [1:0] fuse_row, flash_mode = 2'h0;
	logic [15:0] readback_addr, image_word = 16'h0000;
	logic [5:0] exp_q[$];
	logic [31:0] words[16];
	int fail_count = 0, n_compared = 0, cyc = 0, cs_falls = 0;

	dbcs_top #(.SPI_TIMEOUT_CLOCKS(64)) dut (
		.clock(clock), .rst(rst), .config_osc_clock(config_osc_clock),
		.boot_select(boot_select), .reprogram_request_n(reprogram_request_n),
		.jtag_refresh(jtag_refresh),
		.init_status_n_in(init_status_n_oe ? init_status_n_out : 1'b1),
		.init_status_n_out(init_status_n_out),
		.init_status_n_oe(init_status_n_oe), .done_pin_out(done_pin_out),
		.done_pin_oe(done_pin_oe),
		.done_fuse_programmed(done_fuse_programmed), .sdm_start(sdm_start),
		.sdm_done(sdm_done), .sdm_error(sdm_error), .user_mode(user_mode),
		.config_halted(config_halted), .spi_status(spi_status),
		.config_serial_clock(config_serial_clock),
		.flash_chip_select_n(flash_chip_select_n),
		.flash_mosi_pin(flash_mosi_pin), .flash_miso_pin(flash_miso_pin),
		.fuse_req(fuse_req), .fuse_ack(fuse_ack), .fuse_row(fuse_row),
		.fuse_is_done(fuse_is_done), .fuse_strobe(fuse_strobe),
		.fuse_busy(fuse_busy), .sec_enable(sec_enable),
		.readback_addr(readback_addr), .readback_valid(readback_valid),
		.readback_data(readback_data), .readback_ref(readback_ref),
		.sec_busy(sec_busy), .sec_error(sec_error)
	);
	dbcs_flash_model flash (
		.flash_chip_select_n(flash_chip_select_n),
		.config_serial_clock(config_serial_clock),
		.flash_mosi_pin(flash_mosi_pin), .image_mode(flash_mode),
		.image_word(image_word), .flash_miso_pin(flash_miso_pin),
		.cmd_seen(cmd_seen)
	);

	initial forever #10 clock = ~clock;
	initial begin
		#7;
		forever begin
			#62 config_osc_clock = ~config_osc_clock;
			#63 config_osc_clock = ~config_osc_clock;
		end
	end

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("Compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] crc32(input logic [31:0] c,
		input logic [31:0] d);
		for (int i = 31; i >= 0; i--)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC32_POLY : 32'h00000000);
		return c;
	endfunction

	// Self download partner answers each start after a short delay
	always begin
		@(posedge clock iff sdm_start === 1'b1);
		repeat (20) @(negedge clock);
		sdm_done = 1'b1;
		@(negedge clock);
		sdm_done = 1'b0;
	end

	// Takes the oldest note whenever a final boot result appears
	always @(negedge clock) begin
		if ((user_mode | config_halted) === 1'b1 && !prev_res &&
			exp_q.size() != 0)
			check("boot result",
				{user_mode, config_halted, done_pin_oe, init_status_n_oe,
				spi_status}, exp_q.pop_front());
		prev_res = (user_mode | config_halted) === 1'b1;
	end

	always @(posedge clock) begin
		cyc++;
		if (cyc == LIMIT) begin
			fail_count++;
			end_sim();
		end
	end
	always @(negedge flash_chip_select_n) cs_falls++;

	task automatic run(input logic [1:0] sel, input logic fuse,
		input logic [1:0] mode, input logic serr, input logic [5:0] exp,
		input int acc, input logic use_jtag);
		int start;
		boot_select = sel;
		done_fuse_programmed = fuse;
		flash_mode = mode;
		sdm_error = serr;
		image_word = 16'($urandom);
		start = cs_falls;
		exp_q.push_back(exp);
		if (use_jtag) begin
			jtag_refresh = 1'b1;
			@(negedge clock);
			jtag_refresh = 1'b0;
		end else begin
			reprogram_request_n = 1'b0;
			repeat (4) @(negedge clock);
			reprogram_request_n = 1'b1;
		end
		while (exp_q.size() != 0) @(negedge clock);
		check("flash accesses", cs_falls - start, acc);
		check("done wire", done_pin_oe ? done_pin_out : 1'b1, !exp[3]);
		if (acc != 0)
			check("read command", cmd_seen,
				{8'h03, 24'h000000});
	endtask

	task automatic fuse_seq(input logic erase);
		logic d;
		fuse_req = {1'b1, erase};
		@(negedge clock);
		fuse_req = 2'h0;
		for (int i = 0; i < 5; i++) begin
			d = erase ? (i == 0) : (i == 4);
			check("fuse step",
				{fuse_strobe, fuse_is_done, d ? 2'h0 : fuse_row},
				{1'b1, d, d ? 2'h0 : 2'(erase ? i - 1 : i)});
			fuse_ack = 1'b1;
			@(negedge clock);
			fuse_ack = 1'b0;
		end
		check("fuse busy", fuse_busy, 1'b0);
	endtask

	initial begin
		logic [31:0] c;
		void'($urandom(75370));
		exp_q.push_back(6'h20);
		repeat (16) @(negedge clock);
		rst = 1'b0;
		while (exp_q.size() != 0) @(negedge clock);
		run(2'h0, 1'($urandom), 2'h0, 1'b0, 6'h20, 1, 1'b0);
		run(2'h0, 1'b1, 2'h1, 1'b0, 6'h22, 1, 1'b0);
		run(2'h0, 1'b0, 2'h2, 1'b0, 6'h19, 1, 1'b0);
		run(2'h1, 1'b0, 2'h0, 1'b0, 6'h20, 1, 1'b0);
		run(2'h1, 1'b0, 2'h2, 1'b0, 6'h1D, 1, 1'b0);
		run(2'h1, 1'b1, 2'h0, 1'b1, 6'h20, 1, 1'b0);
		// Test-port restarts only after all pin restarts
		run({1'b1, 1'($urandom)}, 1'b1, 2'h0, 1'b1, 6'h1C, 0, 1'b1);
		c = CRC32_INIT;
		for (int i = 0; i < 16; i++) begin
			words[i] = $urandom;
			c = crc32(c, words[i]);
		end
		readback_ref = c;
		sec_enable = 1'b1;
		run(2'h3, 1'b1, 2'h0, 1'b0, 6'h20, 0, 1'b1);
		// Words are taken only once the check has started and raised sec_busy
		for (int k = 0; k < 4 && sec_busy !== 1'b1; k++) @(negedge clock);
		for (int i = 0; i < 16; i++) begin
			check("readback addr", readback_addr, i);
			readback_data = words[i];
			readback_valid = 1'b1;
			@(negedge clock);
			readback_valid = 1'b0;
			@(negedge clock);
		end
		for (int k = 0; k < 50 && sec_busy === 1'b1; k++) @(negedge clock);
		check("readback result", {sec_busy, sec_error, user_mode}, 3'h1);
		fuse_seq(1'b1);
		fuse_seq(1'b0);
		end_sim();
	end
endmodule
